// file: design/rmyc_core.sv
// rmyc_core: day-of-month, month, year and century flag counters.
// assumes day_tick is a one-cycle pulse from the timebase on sys_clk and
// the register port is driven by the serial bus engine on sys_clk.
//
// Summary of operation
// - month in bits 4:0, BCD 01 to 12
// - year BCD 00 to 99, wraps 99 to 00
// - century flag in month register bit 7
// - year wrap inverts the century flag
// - february 29 days when year divisible by four
// - day counter 01 to month length
`default_nettype none
module rmyc_core
    import rmyc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // timebase
    input wire logic day_tick,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // calendar state
    output logic [7:0] date_out,
    output logic [7:0] month_out,
    output logic [7:0] year_out,
    output logic century_flag
);
    // ***********************************
    // state
    // ***********************************
    logic [7:0] date_q, date_d;
    logic [7:0] month_q, month_d;
    logic [7:0] year_q, year_d;
    logic century_flag_q, century_flag_d;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] date_nxt, month_nxt, year_nxt, last_day;
    logic date_wrap, month_wrap, year_wrap, leap;
    logic wr_date, wr_month, wr_year;

    // ***********************************
    // month length
    // ***********************************
    // multiple of four in BCD: even tens with 0/4/8, odd tens with 2/6
    always_comb begin
        if (year_q[4]) begin
            leap = (year_q[3:0] == 4'h2) || (year_q[3:0] == 4'h6);
        end else begin
            leap = (year_q[3:0] == 4'h0) || (year_q[3:0] == 4'h4) || (year_q[3:0] == 4'h8);
        end
        if (month_q == RMYC_FEB) begin
            last_day = leap ? RMYC_DAYS_29 : RMYC_DAYS_28;
        end else if (month_q == RMYC_APR || month_q == RMYC_JUN || month_q == RMYC_SEP || month_q == RMYC_NOV) begin
            last_day = RMYC_DAYS_30;
        end else begin
            last_day = RMYC_DAYS_31;
        end
    end

    rmyc_bcd_step u_day (
        .cur(date_q),
        .first(RMYC_FIRST_DAY),
        .last(last_day),
        .nxt(date_nxt),
        .wrap(date_wrap)
    );
    rmyc_bcd_step u_month (
        .cur(month_q),
        .first(RMYC_FIRST_MONTH),
        .last(RMYC_LAST_MONTH),
        .nxt(month_nxt),
        .wrap(month_wrap)
    );
    rmyc_bcd_step u_year (
        .cur(year_q),
        .first(RMYC_FIRST_YEAR),
        .last(RMYC_LAST_YEAR),
        .nxt(year_nxt),
        .wrap(year_wrap)
    );

    // ***********************************
    // counting and register writes
    // ***********************************
    // a host write wins over a tick in the same cycle for the written register
    always_comb begin
        wr_date = reg_wr && (reg_addr == RMYC_DATE_OFS);
        wr_month = reg_wr && (reg_addr == RMYC_MONTH_OFS);
        wr_year = reg_wr && (reg_addr == RMYC_YEAR_OFS);
        date_d = date_q;
        month_d = month_q;
        year_d = year_q;
        century_flag_d = century_flag_q;
        if (day_tick) begin
            date_d = date_nxt;
            if (date_wrap) begin
                month_d = month_nxt;
                if (month_wrap) begin
                    year_d = year_nxt;
                    if (year_wrap) begin
                        century_flag_d = ~century_flag_q;
                    end
                end
            end
        end
        if (wr_date) begin
            date_d = {2'b00, reg_wdata[RMYC_DATE_MSB:0]};
        end
        if (wr_month) begin
            month_d = {3'b000, reg_wdata[RMYC_MONTH_MSB:0]};
            century_flag_d = reg_wdata[RMYC_CENT_BIT];
        end
        if (wr_year) begin
            year_d = reg_wdata;
        end
    end

    // ***********************************
    // read data
    // ***********************************
    // unmapped reads answer zero; data holds until the next read
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (reg_addr == RMYC_DATE_OFS) begin
                rdata_d = date_q;
            end else if (reg_addr == RMYC_MONTH_OFS) begin
                rdata_d = {century_flag_q, 2'b00, month_q[RMYC_MONTH_MSB:0]};
            end else if (reg_addr == RMYC_YEAR_OFS) begin
                rdata_d = year_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            date_q <= RMYC_DATE_RST;
            month_q <= RMYC_MONTH_RST;
            year_q <= RMYC_YEAR_RST;
            century_flag_q <= RMYC_CENT_RST;
            rdata_q <= 8'h00;
        end else begin
            date_q <= date_d;
            month_q <= month_d;
            year_q <= year_d;
            century_flag_q <= century_flag_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign date_out = date_q;
    assign month_out = month_q;
    assign year_out = year_q;
    assign century_flag = century_flag_q;

    // ***********************************
    // assertions
    // ***********************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    AST_DEC_TO_JAN: assert property (
        day_tick && !reg_wr && date_q == RMYC_DAYS_31 && month_q == RMYC_LAST_MONTH
        |=> month_q == RMYC_FIRST_MONTH && year_q != $past(year_q))
        else $error("december overflow did not give january and a new year");
    AST_YEAR_WRAP: assert property (
        day_tick && !reg_wr && date_wrap && month_wrap && year_q == RMYC_LAST_YEAR
        |=> year_q == RMYC_FIRST_YEAR)
        else $error("year did not wrap from 99 to 00");
    AST_MONTH_READ: assert property (
        reg_rd && reg_addr == RMYC_MONTH_OFS
        |=> reg_rdata == {$past(century_flag_q), 2'b00, $past(month_q[4:0])})
        else $error("month register read does not show flag and month");
    AST_CENT_TOGGLE: assert property (
        day_tick && !reg_wr && date_wrap && month_wrap && year_wrap
        |=> century_flag_q != $past(century_flag_q))
        else $error("century flag did not invert on year wrap");
    AST_CENT_HOLD: assert property (
        !reg_wr && !(day_tick && date_wrap && month_wrap && year_wrap)
        |=> $stable(century_flag_q))
        else $error("century flag changed without year wrap");
    AST_LEAP_FEB: assert property (
        day_tick && !reg_wr && month_q == RMYC_FEB && date_q == RMYC_DAYS_28
        |=> date_q == ($past(leap) ? RMYC_DAYS_29 : RMYC_FIRST_DAY) && $past(leap) == leap)
        else $error("february 28 step wrong for leap state");
    AST_DAY_LIMIT: assert property (
        day_tick && !reg_wr && date_q == RMYC_DAYS_31
        |=> date_q == RMYC_FIRST_DAY)
        else $error("day 31 did not return to 01");
    AST_MONTH_STEP: assert property (
        day_tick && !reg_wr && date_wrap && month_q < RMYC_LAST_MONTH
        |=> month_q > $past(month_q) && year_q == $past(year_q))
        else $error("day overflow did not advance month alone");
    AST_MONTH_RANGE: assert property (
        day_tick && !reg_wr && date_wrap
        |=> month_q >= RMYC_FIRST_MONTH && month_q <= RMYC_LAST_MONTH)
        else $error("month left 01 to 12 after a month step");
    AST_YEAR_WRITE: assert property (
        reg_wr && reg_addr == RMYC_YEAR_OFS
        |=> year_q == $past(reg_wdata))
        else $error("year write did not land");
    AST_MONTH_WRITE: assert property (
        reg_wr && reg_addr == RMYC_MONTH_OFS
        |=> century_flag_q == $past(reg_wdata[RMYC_CENT_BIT]) && month_q == {3'b000, $past(reg_wdata[4:0])})
        else $error("month write did not split into flag and month");
    AST_YEAR_HOLD: assert property (
        !reg_wr && !(day_tick && date_wrap && month_wrap)
        |=> $stable(year_q))
        else $error("year changed without a month overflow");

    COV_YEAR_WRAP: cover property (day_tick && date_wrap && month_wrap && year_wrap);
    COV_LEAP_DAY: cover property (day_tick && month_q == RMYC_FEB && date_q == RMYC_DAYS_28 && leap);
    COV_MONTH_STEP: cover property (day_tick && date_wrap && !month_wrap);
    COV_MONTH_WRITE: cover property (reg_wr && reg_addr == RMYC_MONTH_OFS && reg_wdata[RMYC_CENT_BIT]);
endmodule
`default_nettype wire

// file: design/rmyc_pkg.sv
// rmyc_pkg: constants shared by the month/year/century calendar block.
// assumes BCD register contents and a byte-wide register port.
`default_nettype none
package rmyc_pkg;
    // ***********************************
    // register offsets
    // ***********************************
    localparam logic [7:0] RMYC_DATE_OFS = 8'h05;
    localparam logic [7:0] RMYC_MONTH_OFS = 8'h07;
    localparam logic [7:0] RMYC_YEAR_OFS = 8'h08;
    // ***********************************
    // field positions
    // ***********************************
    localparam int RMYC_CENT_BIT = 7;
    localparam int RMYC_MONTH_MSB = 4;
    localparam int RMYC_DATE_MSB = 5;
    // ***********************************
    // reset values and counting limits
    // ***********************************
    localparam logic [7:0] RMYC_DATE_RST = 8'h01;
    localparam logic [7:0] RMYC_MONTH_RST = 8'h01;
    localparam logic [7:0] RMYC_YEAR_RST = 8'h00;
    localparam logic RMYC_CENT_RST = 1'b0;
    localparam logic [7:0] RMYC_FIRST_DAY = 8'h01;
    localparam logic [7:0] RMYC_FIRST_MONTH = 8'h01;
    localparam logic [7:0] RMYC_LAST_MONTH = 8'h12;
    localparam logic [7:0] RMYC_FIRST_YEAR = 8'h00;
    localparam logic [7:0] RMYC_LAST_YEAR = 8'h99;
    localparam logic [7:0] RMYC_FEB = 8'h02;
    localparam logic [7:0] RMYC_APR = 8'h04;
    localparam logic [7:0] RMYC_JUN = 8'h06;
    localparam logic [7:0] RMYC_SEP = 8'h09;
    localparam logic [7:0] RMYC_NOV = 8'h11;
    localparam logic [7:0] RMYC_DAYS_28 = 8'h28;
    localparam logic [7:0] RMYC_DAYS_29 = 8'h29;
    localparam logic [7:0] RMYC_DAYS_30 = 8'h30;
    localparam logic [7:0] RMYC_DAYS_31 = 8'h31;
endpackage
`default_nettype wire

// file: design/rmyc_bcd_step.sv
// rmyc_bcd_step: two-digit BCD increment with wrap to a first value.
// assumes purely combinational use by the calendar core.
`default_nettype none
module rmyc_bcd_step (
    // current count and limits
    input wire logic [7:0] cur,
    input wire logic [7:0] first,
    input wire logic [7:0] last,
    // result
    output logic [7:0] nxt,
    output logic wrap
);
    // at-or-above last also wraps, so a bad written value heals in one step
    always_comb begin
        wrap = (cur >= last);
        if (wrap) begin
            nxt = first;
        end else if (cur[3:0] >= 4'h9) begin
            nxt = {cur[7:4] + 4'h1, 4'h0};
        end else begin
            nxt = {cur[7:4], cur[3:0] + 4'h1};
        end
    end
endmodule
`default_nettype wire

// file: tb/rmyc_host_model.sv
// rmyc_host_model: register-port master and day timebase for the calendar core.
// assumes the bench calls its tasks one at a time, after reset is low.
`default_nettype none
module rmyc_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // timebase
    output logic day_tick
);
    timeunit 1ns;
    timeprecision 100ps;
    // ***********************************
    // one-cycle strobes, launched just after an edge
    // ***********************************
    initial begin
        {reg_addr, reg_wdata} = 16'h0000;
        {reg_wr, reg_rd, day_tick} = 3'h0;
    end
    // idle address and data are inverted so stale values cannot pass for a hit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_wdata, reg_wr} = {~a, ~d, 1'b0};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_rd} = {a, 1'b1};
        @(posedge sys_clk);
        #1;
        {reg_addr, reg_rd} = {~a, 1'b0};
        d = reg_rdata;
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
        day_tick = 1'b1;
        @(posedge sys_clk);
        #1;
        day_tick = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/rmyc_core_tb_top.sv
// rmyc_core_tb_top: self-checking bench for the calendar core.
// assumes the host model drives every register-port and timebase input.
`default_nettype none
module rmyc_core_tb_top
    import rmyc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, reset, reg_wr, reg_rd, day_tick, century_flag;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, date_out, month_out, year_out, rv;
    int mismatches = 0;
    int cmp_count = 0;
    rmyc_core dut (.sys_clk(sys_clk), .reset(reset), .day_tick(day_tick), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .date_out(date_out), .month_out(month_out), .year_out(year_out), .century_flag(century_flag));
    rmyc_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .day_tick(day_tick));
    // ***********************************
    // helpers
    // ***********************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // month byte carries the century flag in bit 7
    task automatic step(input logic [7:0] y, m, d, ed, em, ey);
        host.wr(RMYC_DATE_OFS, d);
        host.wr(RMYC_MONTH_OFS, m);
        host.wr(RMYC_YEAR_OFS, y);
        host.tick();
        chk("date", ed, date_out);
        chk("month", em, month_out);
        chk("year", ey, year_out);
    endtask
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_reset();
        chk("rst date", 8'h01, date_out);
        chk("rst month", 8'h01, month_out);
        chk("rst year", 8'h00, year_out);
        chk("rst flag", 8'h00, {7'h00, century_flag});
        host.rd(RMYC_MONTH_OFS, rv);
        chk("rst month rd", 8'h01, rv);
        $display("test reset done");
    endtask
    task automatic t_regs();
        host.wr(RMYC_MONTH_OFS, 8'h92);
        chk("month wr", 8'h12, month_out);
        chk("flag wr", 8'h01, {7'h00, century_flag});
        host.rd(RMYC_MONTH_OFS, rv);
        chk("month rd", 8'h92, rv);
        host.wr(RMYC_MONTH_OFS, 8'he5);
        host.rd(RMYC_MONTH_OFS, rv);
        chk("month rd unused", 8'h85, rv);
        host.wr(RMYC_YEAR_OFS, 8'h99);
        host.wr(8'h20, 8'h55);
        host.rd(8'h20, rv);
        chk("unmapped rd", 8'h00, rv);
        host.rd(RMYC_YEAR_OFS, rv);
        chk("year rd", 8'h99, rv);
        host.wr(RMYC_DATE_OFS, 8'hd7);
        host.rd(RMYC_DATE_OFS, rv);
        chk("date rd", 8'h17, rv);
        $display("test regs done");
    endtask
    task automatic t_wrap();
        for (int c = 0; c < 2; c++) begin
            step(8'h99, {c[0], 7'h12}, 8'h31, 8'h01, 8'h01, 8'h00);
            chk("flag wrap", {7'h00, ~c[0]}, {7'h00, century_flag});
        end
        $display("test wrap done");
    endtask
    task automatic t_month_ends();
        step(8'h24, 8'h02, 8'h28, 8'h29, 8'h02, 8'h24);
        step(8'h00, 8'h02, 8'h28, 8'h29, 8'h02, 8'h00);
        step(8'h23, 8'h02, 8'h28, 8'h01, 8'h03, 8'h23);
        step(8'h12, 8'h02, 8'h28, 8'h29, 8'h02, 8'h12);
        step(8'h18, 8'h02, 8'h28, 8'h01, 8'h03, 8'h18);
        step(8'h10, 8'h09, 8'h30, 8'h01, 8'h10, 8'h10);
        step(8'h10, 8'h01, 8'h09, 8'h10, 8'h01, 8'h10);
        step(8'h24, 8'h02, 8'h29, 8'h01, 8'h03, 8'h24);
        step(8'h10, 8'h04, 8'h30, 8'h01, 8'h05, 8'h10);
        step(8'h10, 8'h01, 8'h30, 8'h31, 8'h01, 8'h10);
        step(8'h10, 8'h01, 8'h31, 8'h01, 8'h02, 8'h10);
        step(8'h98, 8'h12, 8'h31, 8'h01, 8'h01, 8'h99);
        $display("test month ends done");
    endtask
    // ***********************************
    // clock, reset, sequence and watchdog
    // ***********************************
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        reset = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_regs();
        t_wrap();
        t_month_ends();
        results();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        $display("watchdog expired");
        results();
    end
endmodule
`default_nettype wire
